// file: hdl/mtc_pkg.sv
/*
 * Constants, register map and carrier types of the timer/counter block.
 * Assumes a 100 MHz clock that also stands in for the oscillator.
 */
package mtc_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned DIV_RATIO = 12; // Oscillator clocks per tick
    localparam logic [3:0] DIV_LAST = 4'(DIV_RATIO - 1);

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_MODE = 8'h00;  // timer_mode_register
    localparam logic [7:0] OFS_CTRL = 8'h04;  // timer_control_register
    localparam logic [7:0] OFS_T0 = 8'h08;
    localparam logic [7:0] OFS_T1 = 8'h0c;
    localparam logic [7:0] OFS_T2CTL = 8'h10; // timer2_control_register
    localparam logic [7:0] OFS_T2CNT = 8'h14;
    localparam logic [7:0] OFS_CAP = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1c;
    localparam logic [7:0] OFS_MASK = 8'h20;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int MODE_T0_LSB = 0;  // Mode pair of timer 0
    localparam int MODE_T0_CS = 2;   // Counter select of timer 0
    localparam int MODE_T0_GATE = 3;
    localparam int MODE_T1_LSB = 4;
    localparam int MODE_T1_CS = 6;
    localparam int MODE_T1_GATE = 7;
    localparam int CTRL_RUN0 = 0;    // timer0_run_bit
    localparam int CTRL_RUN1 = 1;    // timer1_run_bit
    localparam int T2_CAPSEL = 0;    // capture_reload_select
    localparam int T2_SRC = 1;       // timer2_source_select
    localparam int T2_RUN = 2;       // timer2_run_bit
    localparam int T2_TRIGEN = 3;    // timer2_trigger_enable
    localparam int T2_RXBAUD = 4;    // receive baud select
    localparam int T2_TXBAUD = 5;    // transmit_baud_select
    localparam int ST_T0 = 0;        // timer0_overflow_flag
    localparam int ST_T1 = 1;        // timer1_overflow_flag
    localparam int ST_T2 = 2;        // timer2_overflow_flag
    localparam int ST_TRIG = 3;      // timer2_trigger_flag

    // ----------------------------------------
    // Modes and reset values
    // ----------------------------------------
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [15:0] WORD_MAX = 16'hffff;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIB = 4'h0;

    // Sampled pin levels, one bit per pin
    typedef struct packed {
        logic t0_cnt;
        logic t1_cnt;
        logic t2_cnt;
        logic t2_trig;
    } mtc_pins_s;

    // Whole state of the block
    typedef struct packed {
        logic [7:0] mode;
        logic [1:0] run;
        logic [7:0] t0_low;
        logic [7:0] t0_high;
        logic [7:0] t1_low;
        logic [7:0] t1_high;
        logic [5:0] t2ctl;
        logic [15:0] t2_cnt;
        logic [15:0] cap;
        logic [3:0] stat;
        logic [3:0] mask;
        logic [3:0] div;
        mtc_pins_s prev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic t1_baud;
        logic t2_baud;
    } mtc_state_s;

endpackage

// file: hdl/mtc_top.sv
/*
 * Timer/counter block: timers 0 and 1 (auto-reload and split modes),
 * timer 2 (capture and baud-generator modes), APB register slave,
 * sticky status with mask and one interrupt line.
 * Assumes pins synchronous to REF_CLK_IN and a zero-wait APB master.
 */
`timescale 1ns/1ps

// How it works
// - Mode 2 low byte wraps, flags, reloads
// - Reload leaves the high byte untouched
// - Count only when run and gate allow
// - Tick is divide-by-12 or count pin
// - Timer 1 mode 3 freezes its count
// - Timer 0 mode 3 splits two bytes
// - Split low byte source from mode bit 2
// - Split high byte uses timer 1 run bit, flag
// - Split-mode timer 1 runs without run bit, flag
// - Timer 1 overflow drives baud output
// - Timer 2 source select and run bit
// - Capture mode wrap sets timer 2 flag
// - Trigger edge captures count, sets flag
// - Baud select gives reload, no flag
// - Baud mode trigger edge sets flag
// - Vector acknowledge clears timer 0/1 flags
module mtc_top (
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic TIMER0_COUNT_PIN_IN,
    input wire logic TIMER1_COUNT_PIN_IN,
    input wire logic TIMER2_COUNT_PIN_IN,
    input wire logic TIMER2_TRIGGER_PIN_IN,
    input wire logic EXTERNAL_INTERRUPT0_PIN_IN,
    input wire logic EXTERNAL_INTERRUPT1_PIN_IN,
    input wire logic TIMER0_VECTOR_IN,
    input wire logic TIMER1_VECTOR_IN,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic [31:0] PRDATA_OUT,
    output logic IRQ_OUT,
    output logic TIMER1_BAUD_OUT,
    output logic TIMER2_BAUD_OUT
);

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------

    // Address hits a mapped register
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == mtc_pkg::OFS_MODE) || (a == mtc_pkg::OFS_CTRL) ||
                  (a == mtc_pkg::OFS_T0) || (a == mtc_pkg::OFS_T1) ||
                  (a == mtc_pkg::OFS_T2CTL) ||
                  (a == mtc_pkg::OFS_T2CNT) ||
                  (a == mtc_pkg::OFS_CAP) || (a == mtc_pkg::OFS_STAT) ||
                  (a == mtc_pkg::OFS_MASK);
    endfunction

    // Read value of one register, unused bits zero
    function automatic logic [31:0] read_reg(
        input mtc_pkg::mtc_state_s s,
        input logic [7:0] a
    );
        read_reg = 32'h0000_0000;
        case (a)
            mtc_pkg::OFS_MODE: read_reg[7:0] = s.mode;
            mtc_pkg::OFS_CTRL: read_reg[1:0] = s.run;
            mtc_pkg::OFS_T0: read_reg[15:0] = {s.t0_high, s.t0_low};
            mtc_pkg::OFS_T1: read_reg[15:0] = {s.t1_high, s.t1_low};
            mtc_pkg::OFS_T2CTL: read_reg[5:0] = s.t2ctl;
            mtc_pkg::OFS_T2CNT: read_reg[15:0] = s.t2_cnt;
            mtc_pkg::OFS_CAP: read_reg[15:0] = s.cap;
            mtc_pkg::OFS_STAT: read_reg[3:0] = s.stat;
            mtc_pkg::OFS_MASK: read_reg[3:0] = s.mask;
            default: read_reg = 32'h0000_0000;
        endcase
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    mtc_pkg::mtc_state_s st_r;
    mtc_pkg::mtc_state_s st_nxt;
    mtc_pkg::mtc_pins_s pins;
    mtc_pkg::mtc_pins_s fall;

    // Pin levels and their falling edges
    assign pins = '{t0_cnt: TIMER0_COUNT_PIN_IN,
                    t1_cnt: TIMER1_COUNT_PIN_IN,
                    t2_cnt: TIMER2_COUNT_PIN_IN,
                    t2_trig: TIMER2_TRIGGER_PIN_IN};
    assign fall = st_r.prev & ~pins;

    // ----------------------------------------
    // Next state
    // ----------------------------------------

    // Counting, flags and register access in one pass
    always_comb begin
        logic div_tick;
        logic [1:0] m0;
        logic [1:0] m1;
        logic split;
        logic tick0;
        logic tick1;
        logic tick2;
        logic en0;
        logic en1;
        logic baud;
        logic acc;
        logic wr;
        logic [3:0] set;
        logic [3:0] clr;
        div_tick = 1'b0;
        m0 = 2'h0;
        m1 = 2'h0;
        split = 1'b0;
        tick0 = 1'b0;
        tick1 = 1'b0;
        tick2 = 1'b0;
        en0 = 1'b0;
        en1 = 1'b0;
        baud = 1'b0;
        acc = 1'b0;
        wr = 1'b0;
        set = mtc_pkg::RST_NIB;
        clr = mtc_pkg::RST_NIB;
        st_nxt = st_r;
        st_nxt.prev = pins;
        st_nxt.t1_baud = 1'b0;
        st_nxt.t2_baud = 1'b0;

        // Prescaler: one tick every twelve clocks
        div_tick = (st_r.div == mtc_pkg::DIV_LAST);
        st_nxt.div = div_tick ? mtc_pkg::RST_NIB : st_r.div + 4'h1;

        m0 = st_r.mode[mtc_pkg::MODE_T0_LSB +: 2];
        m1 = st_r.mode[mtc_pkg::MODE_T1_LSB +: 2];
        split = (m0 == mtc_pkg::MODE_SPLIT);

        tick0 = st_r.mode[mtc_pkg::MODE_T0_CS] ? fall.t0_cnt : div_tick;
        tick1 = st_r.mode[mtc_pkg::MODE_T1_CS] ? fall.t1_cnt : div_tick;
        // run bit and gate with interrupt pin
        en0 = st_r.run[mtc_pkg::CTRL_RUN0] &&
              (!st_r.mode[mtc_pkg::MODE_T0_GATE] ||
               EXTERNAL_INTERRUPT0_PIN_IN);
        // run bit not used while timer 0 is split
        en1 = (split || st_r.run[mtc_pkg::CTRL_RUN1]) &&
              (!st_r.mode[mtc_pkg::MODE_T1_GATE] ||
               EXTERNAL_INTERRUPT1_PIN_IN);

        // Timer 0 low byte
        if (en0 && tick0) begin
            if (m0 == mtc_pkg::MODE_RELOAD) begin
                // high byte kept as reload value
                if (st_r.t0_low == mtc_pkg::BYTE_MAX) begin
                    st_nxt.t0_low = st_r.t0_high;
                    set[mtc_pkg::ST_T0] = 1'b1;
                end else begin
                    st_nxt.t0_low = st_r.t0_low + 8'h01;
                end
            end else if (split) begin
                // low byte as free 8-bit counter
                // source picked by mode bit 2
                st_nxt.t0_low = st_r.t0_low + 8'h01;
                if (st_r.t0_low == mtc_pkg::BYTE_MAX) begin
                    set[mtc_pkg::ST_T0] = 1'b1;
                end
            end
        end

        // split high byte on timer 1 run bit and flag
        if (split && st_r.run[mtc_pkg::CTRL_RUN1] && div_tick) begin
            st_nxt.t0_high = st_r.t0_high + 8'h01;
            if (st_r.t0_high == mtc_pkg::BYTE_MAX) begin
                set[mtc_pkg::ST_T1] = 1'b1;
            end
        end

        // Timer 1; mode 3 leaves the count frozen
        if (en1 && tick1 && (m1 == mtc_pkg::MODE_RELOAD)) begin
            if (st_r.t1_low == mtc_pkg::BYTE_MAX) begin
                // timer 1 reload from high byte
                st_nxt.t1_low = st_r.t1_high;
                // overflow pulse for the serial port
                st_nxt.t1_baud = 1'b1;
                // flag belongs to split high byte
                if (!split) begin
                    set[mtc_pkg::ST_T1] = 1'b1;
                end
            end else begin
                st_nxt.t1_low = st_r.t1_low + 8'h01;
            end
        end

        // timer 2 source and run bit
        tick2 = st_r.t2ctl[mtc_pkg::T2_SRC] ? fall.t2_cnt : div_tick;
        baud = st_r.t2ctl[mtc_pkg::T2_RXBAUD] ||
               st_r.t2ctl[mtc_pkg::T2_TXBAUD];
        if (st_r.t2ctl[mtc_pkg::T2_RUN] && tick2) begin
            if (baud) begin
                if (st_r.t2_cnt == mtc_pkg::WORD_MAX) begin
                    st_nxt.t2_cnt = st_r.cap;
                    st_nxt.t2_baud = 1'b1;
                end else begin
                    st_nxt.t2_cnt = st_r.t2_cnt + 16'h0001;
                end
            end else if (st_r.t2ctl[mtc_pkg::T2_CAPSEL]) begin
                // 16-bit up count, wrap sets flag
                st_nxt.t2_cnt = st_r.t2_cnt + 16'h0001;
                if (st_r.t2_cnt == mtc_pkg::WORD_MAX) begin
                    set[mtc_pkg::ST_T2] = 1'b1;
                end
            end
        end

        // Trigger pin falling edge
        if (st_r.t2ctl[mtc_pkg::T2_TRIGEN] && fall.t2_trig) begin
            if (baud) begin
                set[mtc_pkg::ST_TRIG] = 1'b1;
            end else if (st_r.t2ctl[mtc_pkg::T2_CAPSEL]) begin
                st_nxt.cap = st_r.t2_cnt;
                set[mtc_pkg::ST_TRIG] = 1'b1;
            end
        end

        // APB: one wait cycle, then answer
        acc = PSEL_IN && PENABLE_IN;
        if (acc && !st_r.pready) begin
            st_nxt.pready = 1'b1;
            // Read data only on reads, so it stands until the next read
            if (!PWRITE_IN) begin
                st_nxt.prdata = read_reg(st_r, PADDR_IN);
            end
            st_nxt.pslverr = !addr_ok(PADDR_IN);
        end else begin
            st_nxt.pready = 1'b0;
            st_nxt.pslverr = 1'b0;
        end
        wr = acc && st_r.pready && PWRITE_IN;

        // Register writes override counting
        if (wr) begin
            case (PADDR_IN)
                mtc_pkg::OFS_MODE: st_nxt.mode = PWDATA_IN[7:0];
                mtc_pkg::OFS_CTRL: st_nxt.run = PWDATA_IN[1:0];
                mtc_pkg::OFS_T0: begin
                    st_nxt.t0_low = PWDATA_IN[7:0];
                    st_nxt.t0_high = PWDATA_IN[15:8];
                end
                mtc_pkg::OFS_T1: begin
                    st_nxt.t1_low = PWDATA_IN[7:0];
                    st_nxt.t1_high = PWDATA_IN[15:8];
                end
                mtc_pkg::OFS_T2CTL: st_nxt.t2ctl = PWDATA_IN[5:0];
                mtc_pkg::OFS_T2CNT: st_nxt.t2_cnt = PWDATA_IN[15:0];
                mtc_pkg::OFS_CAP: st_nxt.cap = PWDATA_IN[15:0];
                mtc_pkg::OFS_STAT: clr = PWDATA_IN[3:0];
                mtc_pkg::OFS_MASK: st_nxt.mask = PWDATA_IN[3:0];
                default: clr = mtc_pkg::RST_NIB;
            endcase
        end

        // vector acknowledge clears timer 0/1 flags
        clr[mtc_pkg::ST_T0] = clr[mtc_pkg::ST_T0] | TIMER0_VECTOR_IN;
        clr[mtc_pkg::ST_T1] = clr[mtc_pkg::ST_T1] | TIMER1_VECTOR_IN;
        // timer 2 flags only cleared by software
        st_nxt.stat = (st_r.stat & ~clr) | set;

        // Interrupt level from unmasked sticky flags
        st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------

    // State register with asynchronous reset
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            st_r <= '0;
            st_r.prev <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign PREADY_OUT = st_r.pready;
    assign PSLVERR_OUT = st_r.pslverr;
    assign PRDATA_OUT = st_r.prdata;
    assign IRQ_OUT = st_r.irq;
    assign TIMER1_BAUD_OUT = st_r.t1_baud;
    assign TIMER2_BAUD_OUT = st_r.t2_baud;

endmodule

// file: testbench/mtc_pins_model.sv
/* Far-side pin model: count and trigger pins idle high, gate pins
 * low until the bench raises them.
 * Assumes the bench calls its tasks hierarchically. */
`timescale 1ns/1ps
module mtc_pins_model (
    input wire logic clk_in,
    output mtc_pkg::mtc_pins_s pins_out,
    output logic [1:0] gate_out
);
    // Idle levels from time zero
    initial begin
        pins_out = '1;
        gate_out = 2'h0;
    end

    // One falling edge; index 0 t0, 1 t1, 2 t2 count, 3 trigger
    task automatic fall(input int k);
        @(posedge clk_in);
        pins_out[3-k] <= 1'b0;
        repeat (2) @(posedge clk_in);
        pins_out[3-k] <= 1'b1;
        repeat (2) @(posedge clk_in);
    endtask

    // Gate pin level change
    task automatic gate(input int k, input logic v);
        @(posedge clk_in);
        gate_out[k] <= v;
    endtask
endmodule

// file: testbench/mtc_properties.sv
/* Checker of the timer block's bus answers and output pulses.
 * Assumes it is bound to mtc_top and sees only its ports. */
`timescale 1ns/1ps
module mtc_properties (
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic TIMER0_VECTOR_IN,
    input wire logic TIMER1_VECTOR_IN,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic IRQ_OUT,
    input wire logic TIMER1_BAUD_OUT,
    input wire logic TIMER2_BAUD_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    // Bus answer: one wait state, one-cycle ready, error beside ready
    a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held longer than one cycle");
    a_ready_wait: assert property (
        PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
        else $error("ready missing after first access cycle");
    a_error_with_ready: assert property (
        PSLVERR_OUT |-> PREADY_OUT && PSEL_IN)
        else $error("error flag outside a bus answer");
    a_rdata_holds: assert property (
        $changed(PRDATA_OUT) |-> PREADY_OUT && !PWRITE_IN)
        else $error("read data moved outside a read answer");
    a_reset_quiet: assert property ($rose(RST_B_IN) |->
        !(PREADY_OUT || IRQ_OUT || TIMER1_BAUD_OUT || TIMER2_BAUD_OUT))
        else $error("output active at first edge after reset");
    // timer 1 baud clock is a single pulse
    a_baud1_pulse: assert property (
        TIMER1_BAUD_OUT |=> !TIMER1_BAUD_OUT)
        else $error("timer 1 baud pulse too long");
    // timer 2 reload pulse is a single pulse
    a_baud2_pulse: assert property (
        TIMER2_BAUD_OUT |=> !TIMER2_BAUD_OUT)
        else $error("timer 2 baud pulse too long");
    // interrupt drops only by write or vector
    a_irq_fall_cause: assert property (
        $fell(IRQ_OUT) |-> $past(PREADY_OUT && PWRITE_IN) ||
        $past(TIMER0_VECTOR_IN) || $past(TIMER1_VECTOR_IN))
        else $error("interrupt dropped without a cause");
endmodule

// file: testbench/mtc_top_bench.sv
/* Self-checking bench of the timer block: APB tasks, one task per
 * scenario, pin model on the far side.
 * Assumes mtc_top, mtc_pins_model and mtc_properties compiled. */
`timescale 1ns/1ps
module mtc_top_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic vec0 = 1'b0;
    logic vec1 = 1'b0;
    mtc_pkg::mtc_pins_s pins;
    logic [1:0] gates;
    logic pready, pslverr, irq, b1, b2, err;
    logic [31:0] prdata, rd;
    int errors = 0;
    int checks = 0;
    int n;

    // Clock at 100 MHz
    always #5 clk = ~clk;

    mtc_top i_mtc_top (.REF_CLK_IN(clk), .RST_B_IN(rst_b),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(pa), .PWDATA_IN(pwd),
        .TIMER0_COUNT_PIN_IN(pins.t0_cnt),
        .TIMER1_COUNT_PIN_IN(pins.t1_cnt),
        .TIMER2_COUNT_PIN_IN(pins.t2_cnt),
        .TIMER2_TRIGGER_PIN_IN(pins.t2_trig),
        .EXTERNAL_INTERRUPT0_PIN_IN(gates[0]),
        .EXTERNAL_INTERRUPT1_PIN_IN(gates[1]),
        .TIMER0_VECTOR_IN(vec0), .TIMER1_VECTOR_IN(vec1),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .PRDATA_OUT(prdata), .IRQ_OUT(irq),
        .TIMER1_BAUD_OUT(b1), .TIMER2_BAUD_OUT(b2));
    mtc_pins_model i_mtc_pins_model (.clk_in(clk), .pins_out(pins),
        .gate_out(gates));

    // Compare and count
    task automatic chk(input string s, input logic [31:0] e,
        input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", s, e, g);
            errors++;
        end
    endtask

    // One APB transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        logic ok;
        k = 0;
        ok = 1'b0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        // Look mid-cycle, then pass the edge at which ready stands high
        while (!ok && k < 20) begin
            @(negedge clk);
            k++;
            ok = (pready === 1'b1);
            rd = prdata;
            err = pslverr;
            @(posedge clk);
        end
        if (!ok) errors++;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
        input string s);
        apb(1'b0, a, 32'h0);
        chk(s, e, rd);
    endtask

    // One-cycle vector acknowledge
    task automatic vec(input int k);
        @(posedge clk);
        if (k == 0) vec0 <= 1'b1;
        else vec1 <= 1'b1;
        @(posedge clk);
        vec0 <= 1'b0;
        vec1 <= 1'b0;
        @(posedge clk);
    endtask

    // Reset values and an unmapped place
    task automatic t_reset;
        rdc(mtc_pkg::OFS_MODE, 32'h0, "mode");
        rdc(mtc_pkg::OFS_STAT, 32'h0, "status");
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped error", 32'h1, err);
        chk("unmapped data", 32'h0, rd);
        $display("test reset done");
    endtask

    task automatic t_reload;
        wr(mtc_pkg::OFS_T0, 32'hfdfe);
        wr(mtc_pkg::OFS_MASK, 32'h1);
        wr(mtc_pkg::OFS_MODE, 32'h2);
        wr(mtc_pkg::OFS_CTRL, 32'h1);
        repeat (40) @(posedge clk);
        wr(mtc_pkg::OFS_CTRL, 32'h0);
        chk("irq set", 32'h1, irq);
        apb(1'b0, mtc_pkg::OFS_T0, 32'h0);
        chk("t0 reload byte", 32'hfd, rd[15:8]);
        vec(0);
        chk("irq cleared", 32'h0, irq);
        $display("test reload done");
    endtask

    // gate pin holds and releases the count
    task automatic t_gate;
        wr(mtc_pkg::OFS_T0, 32'h10);
        wr(mtc_pkg::OFS_MODE, 32'ha);
        wr(mtc_pkg::OFS_CTRL, 32'h1);
        repeat (40) @(posedge clk);
        rdc(mtc_pkg::OFS_T0, 32'h10, "gated t0");
        i_mtc_pins_model.gate(0, 1'b1);
        repeat (40) @(posedge clk);
        apb(1'b0, mtc_pkg::OFS_T0, 32'h0);
        chk("ungated t0", 32'h1, rd[7:0] != 8'h10);
        wr(mtc_pkg::OFS_CTRL, 32'h0);
        i_mtc_pins_model.gate(0, 1'b0);
        $display("test gate done");
    endtask

    // pin falls counted, wrap reloads zero
    task automatic t_pin;
        wr(mtc_pkg::OFS_STAT, 32'hf);
        wr(mtc_pkg::OFS_T0, 32'hfe);
        wr(mtc_pkg::OFS_MODE, 32'h6);
        wr(mtc_pkg::OFS_CTRL, 32'h1);
        i_mtc_pins_model.fall(0);
        i_mtc_pins_model.fall(0);
        wr(mtc_pkg::OFS_CTRL, 32'h0);
        rdc(mtc_pkg::OFS_T0, 32'h0, "t0 pin count");
        rdc(mtc_pkg::OFS_STAT, 32'h1, "t0 pin flag");
        $display("test pin done");
    endtask

    task automatic t_split;
        wr(mtc_pkg::OFS_T1, 32'h55);
        wr(mtc_pkg::OFS_MODE, 32'h30);
        wr(mtc_pkg::OFS_CTRL, 32'h2);
        repeat (40) @(posedge clk);
        rdc(mtc_pkg::OFS_T1, 32'h55, "t1 frozen");
        wr(mtc_pkg::OFS_CTRL, 32'h0);
        wr(mtc_pkg::OFS_STAT, 32'hf);
        wr(mtc_pkg::OFS_T0, 32'hfefe);
        wr(mtc_pkg::OFS_T1, 32'hfefe);
        wr(mtc_pkg::OFS_MODE, 32'h23);
        wr(mtc_pkg::OFS_CTRL, 32'h1);
        n = 0;
        repeat (60) begin
            @(negedge clk);
            if (b1 === 1'b1) n++;
        end
        chk("t1 baud seen", 32'h1, n > 0);
        rdc(mtc_pkg::OFS_STAT, 32'h1, "split status");
        apb(1'b0, mtc_pkg::OFS_T0, 32'h0);
        chk("split high idle", 32'hfe, rd[15:8]);
        wr(mtc_pkg::OFS_CTRL, 32'h3);
        repeat (40) @(posedge clk);
        rdc(mtc_pkg::OFS_STAT, 32'h3, "split high flag");
        vec(1);
        rdc(mtc_pkg::OFS_STAT, 32'h1, "t1 vector");
        wr(mtc_pkg::OFS_CTRL, 32'h0);
        $display("test split done");
    endtask

    // timer 1 pin count under its gate, reset after the stop
    task automatic t_t1pin;
        wr(mtc_pkg::OFS_MODE, 32'he0);
        wr(mtc_pkg::OFS_STAT, 32'hf);
        wr(mtc_pkg::OFS_T1, 32'hfe);
        wr(mtc_pkg::OFS_CTRL, 32'h2);
        i_mtc_pins_model.fall(1);
        rdc(mtc_pkg::OFS_T1, 32'hfe, "t1 gated pin");
        i_mtc_pins_model.gate(1, 1'b1);
        i_mtc_pins_model.fall(1);
        i_mtc_pins_model.fall(1);
        rdc(mtc_pkg::OFS_T1, 32'h0, "t1 pin wrap");
        rdc(mtc_pkg::OFS_STAT, 32'h2, "t1 pin flag");
        wr(mtc_pkg::OFS_CTRL, 32'h0);
        i_mtc_pins_model.gate(1, 1'b0);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rdc(mtc_pkg::OFS_MODE, 32'h0, "mode after reset");
        $display("test timer 1 pin done");
    endtask

    task automatic t_capture;
        wr(mtc_pkg::OFS_MODE, 32'h0);
        wr(mtc_pkg::OFS_STAT, 32'hf);
        wr(mtc_pkg::OFS_MASK, 32'hc);
        wr(mtc_pkg::OFS_T2CNT, 32'hfffe);
        wr(mtc_pkg::OFS_T2CTL, 32'hf);
        i_mtc_pins_model.fall(2);
        i_mtc_pins_model.fall(2);
        chk("t2 irq", 32'h1, irq);
        rdc(mtc_pkg::OFS_STAT, 32'h4, "t2 wrap flag");
        rdc(mtc_pkg::OFS_T2CNT, 32'h0, "t2 count");
        wr(mtc_pkg::OFS_T2CTL, 32'h9);
        wr(mtc_pkg::OFS_T2CNT, 32'h1234);
        i_mtc_pins_model.fall(3);
        rdc(mtc_pkg::OFS_CAP, 32'h1234, "capture");
        vec(0);
        vec(1);
        rdc(mtc_pkg::OFS_STAT, 32'hc, "t2 flags kept");
        wr(mtc_pkg::OFS_STAT, 32'hc);
        rdc(mtc_pkg::OFS_STAT, 32'h0, "t2 flags cleared");
        chk("irq low", 32'h0, irq);
        $display("test capture done");
    endtask

    // both baud selects, reload, trigger flag
    task automatic t_baud;
        logic [31:0] c;
        for (int i = 0; i < 2; i++) begin
            c = (i == 0) ? 32'h1c : 32'h2c;
            wr(mtc_pkg::OFS_T2CTL, 32'h0);
            wr(mtc_pkg::OFS_CAP, 32'hfffe);
            wr(mtc_pkg::OFS_T2CNT, 32'hfffe);
            wr(mtc_pkg::OFS_T2CTL, c);
            n = 0;
            repeat (120) begin
                @(negedge clk);
                if (b2 === 1'b1) n++;
            end
            wr(mtc_pkg::OFS_T2CTL, c ^ 32'h4);
            chk("t2 baud pulses", 32'h1, n >= 4);
            apb(1'b0, mtc_pkg::OFS_T2CNT, 32'h0);
            chk("t2 reload", 32'h7fff, rd[15:1]);
            rdc(mtc_pkg::OFS_STAT, 32'h0, "no wrap flag");
            i_mtc_pins_model.fall(3);
            rdc(mtc_pkg::OFS_STAT, 32'h8, "baud trigger");
            wr(mtc_pkg::OFS_STAT, 32'h8);
        end
        $display("test baud done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Main sequence after six reset cycles
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_reload;
        t_gate;
        t_pin;
        t_split;
        t_t1pin;
        t_capture;
        t_baud;
        tally_and_finish;
    end

    // Watchdog well beyond the expected run length
    initial begin
        #100000;
        errors++;
        tally_and_finish;
    end
endmodule

bind mtc_top mtc_properties i_mtc_properties (
    .REF_CLK_IN(REF_CLK_IN), .RST_B_IN(RST_B_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
    .TIMER0_VECTOR_IN(TIMER0_VECTOR_IN),
    .TIMER1_VECTOR_IN(TIMER1_VECTOR_IN), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .PRDATA_OUT(PRDATA_OUT),
    .IRQ_OUT(IRQ_OUT), .TIMER1_BAUD_OUT(TIMER1_BAUD_OUT),
    .TIMER2_BAUD_OUT(TIMER2_BAUD_OUT));
